// [inc/acd_pkg.sv]
package acd_pkg;
  localparam int unsigned AW = 16;
  localparam int unsigned DW = 32;
  localparam int unsigned RW = 16;
  // register indexes; byte address is four times the index
  localparam logic [11:0] IDX_IF2_CLK = 12'h204;
  localparam logic [11:0] IDX_GATES = 12'h208;
  localparam logic [11:0] IDX_AUX_DIV = 12'h209;
  localparam logic [11:0] IDX_IF1_RATE = 12'h210;
  localparam logic [11:0] IDX_STATUS = 12'h2ff;
  localparam logic [RW-1:0] IF2_CLK_RST = 16'h0000;
  localparam logic [RW-1:0] GATES_RST = 16'h0000;
  localparam logic [RW-1:0] AUX_DIV_RST = 16'h0000;
  localparam logic [RW-1:0] IF1_RATE_RST = 16'h0083;
  localparam logic [3:0] SR_MAX = 4'ha;
  localparam logic [3:0] RATIO_MIN = 4'h1;
  localparam logic [3:0] RATIO_MAX = 4'h9;
  localparam int unsigned DIV_W = 17;
  localparam logic [4:0] TO_BASE_BIT = 5'h07;
  localparam logic [4:0] DB_CODE0_BIT = 5'h07;
  localparam logic [4:0] DB_BASE_BIT = 5'h09;
  localparam int unsigned NGATE = 5;

  typedef struct packed {
    logic [10:0] rsvd;
    logic [1:0] src;
    logic inv;
    logic halve;
    logic ena;
  } acd_if2_clk_s;

  typedef struct packed {
    logic [10:0] rsvd;
    logic to_ena;
    logic p1_ena;
    logic p2_ena;
    logic mix_ena;
    logic sys_src;
  } acd_gates_s;

  typedef struct packed {
    logic [4:0] rsvd_a;
    logic [2:0] to_div;
    logic rsvd_b;
    logic [2:0] db_div;
    logic rsvd_c;
    logic [2:0] op_div;
  } acd_aux_div_s;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [3:0] sr;
    logic [3:0] ratio;
  } acd_rate_s;

  typedef struct packed {
    logic [1:0] src;
    logic inv;
    logic halve;
  } acd_if2_cfg_s;

  typedef enum logic [1:0] {
    CS_RUN = 2'b01,
    CS_PARK = 2'b10
  } acd_csw_e;

  function automatic logic [15:0] reg_addr(input logic [11:0] idx);
    reg_addr = {2'h0, idx, 2'h0};
  endfunction

  function automatic logic [10:0] ratio_value(input logic [3:0] code);
    logic [10:0] lut [0:15];
    lut = '{11'h000, 11'h080, 11'h0c0, 11'h100, 11'h180, 11'h200, 11'h300,
      11'h400, 11'h580, 11'h600, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000,
      11'h000};
    ratio_value = lut[code];
  endfunction

  // half periods of the gpio clock, in system clock edges
  function automatic logic [4:0] op_edges(input logic [2:0] code);
    logic [4:0] lut [0:7];
    lut = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10};
    op_edges = lut[code];
  endfunction
endpackage

// [rtl/acd_clock_ctrl.sv]
// Function
// - second port clock from four sources
// - invert bit inverts second port clock
// - halve bit divides second port clock
// - enable bit gates second port clock
// - timeout clock runs only when enabled
// - first port processing clock gate
// - second port processing clock gate
// - mixer processing clock gate
// - system clock from first or second
// - timeout clock divides reference 256 to 32768
// - debounce clock divides reference, 256 to 131072
// - gpio clock divides system clock
// - first port sample rate code, 48k reset
// - first port clock ratio code, 256 reset
`timescale 1ns/10ps
module acd_clock_ctrl (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primary_master_clock,
  input wire logic secondary_master_clock,
  input wire logic first_locked_loop,
  input wire logic second_locked_loop,
  input wire logic first_port_clock,
  input wire logic ref_256k_clock,
  output logic second_port_clock,
  output logic system_clock,
  output logic first_port_proc_clock,
  output logic second_port_proc_clock,
  output logic mixer_proc_clock,
  output logic timeout_clock,
  output logic debounce_clock,
  output logic gpio_out_clock,
  output logic [3:0] first_port_sample_rate,
  output logic [3:0] first_port_clock_ratio,
  output logic [10:0] first_port_ratio_value,
  output logic first_port_rate_invalid
);
  localparam int unsigned NSYNC = 6;

  acd_pkg::acd_if2_clk_s if2_ff;
  acd_pkg::acd_gates_s gates_ff;
  acd_pkg::acd_aux_div_s aux_ff;
  acd_pkg::acd_rate_s rate_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  // pin clocks pass two flops before use
  logic [NSYNC-1:0] sync_a_ff;
  logic [NSYNC-1:0] sync_b_ff;
  wire [NSYNC-1:0] pins = {ref_256k_clock, first_port_clock,
    second_locked_loop, first_locked_loop,
    secondary_master_clock, primary_master_clock};

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync_a_ff <= '0;
      sync_b_ff <= '0;
    end else begin
      sync_a_ff <= pins;
      sync_b_ff <= sync_a_ff;
    end
  end

  wire [3:0] src_vec = sync_b_ff[3:0];
  wire p1_raw = sync_b_ff[4];
  wire ref_raw = sync_b_ff[5];

  // ---------------- apb slave ----------------
  wire acc = psel && penable;
  wire first_acc = acc && !pready_ff;
  wire done = acc && pready_ff;
  wire hit_if2 = paddr == acd_pkg::reg_addr(acd_pkg::IDX_IF2_CLK);
  wire hit_gat = paddr == acd_pkg::reg_addr(acd_pkg::IDX_GATES);
  wire hit_aux = paddr == acd_pkg::reg_addr(acd_pkg::IDX_AUX_DIV);
  wire hit_rat = paddr == acd_pkg::reg_addr(acd_pkg::IDX_IF1_RATE);
  wire hit_sts = paddr == acd_pkg::reg_addr(acd_pkg::IDX_STATUS);
  wire hit_any = hit_if2 || hit_gat || hit_aux || hit_rat || hit_sts;
  // status register is read only
  wire bad = !hit_any || (pwrite && hit_sts);
  wire wr_ok = done && pwrite && !pslverr_ff;
  wire [15:0] wd = pwdata[15:0];

  acd_pkg::acd_if2_clk_s nxt_if2;
  acd_pkg::acd_gates_s nxt_gates;
  acd_pkg::acd_aux_div_s nxt_aux;
  acd_pkg::acd_rate_s nxt_rate;
  assign nxt_if2 = {11'h000, wd[4:0]};
  assign nxt_gates = {11'h000, wd[4:0]};
  assign nxt_aux = {5'h00, wd[10:8], 1'b0, wd[6:4], 1'b0, wd[2:0]};
  assign nxt_rate = {8'h00, wd[7:0]};

  logic [15:0] status_w;
  wire [15:0] rd_mux = hit_if2 ? if2_ff :
                      hit_gat ? gates_ff :
                      hit_aux ? aux_ff :
                      hit_rat ? rate_ff :
                      hit_sts ? status_w : 16'h0000;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= first_acc;
      pslverr_ff <= first_acc && bad;
      if (first_acc) begin
        prdata_ff <= (pwrite || bad) ? 32'h0000_0000 : {16'h0000, rd_mux};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      if2_ff <= acd_pkg::IF2_CLK_RST;
      gates_ff <= acd_pkg::GATES_RST;
      aux_ff <= acd_pkg::AUX_DIV_RST;
      rate_ff <= acd_pkg::IF1_RATE_RST;
    end else if (wr_ok) begin
      if (hit_if2) if2_ff <= nxt_if2;
      if (hit_gat) gates_ff <= nxt_gates;
      if (hit_aux) aux_ff <= nxt_aux;
      if (hit_rat) rate_ff <= nxt_rate;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ---------------- second port clock ----------------
  acd_pkg::acd_csw_e csw_ff;
  acd_pkg::acd_if2_cfg_s act_ff;
  logic half_ff;
  logic mux_prev_ff;
  wire acd_pkg::acd_if2_cfg_s req = {if2_ff.src, if2_ff.inv, if2_ff.halve};
  wire run = csw_ff == acd_pkg::CS_RUN;
  wire muxed = src_vec[act_ff.src] ^ act_ff.inv;
  wire req_lvl = src_vec[req.src] ^ req.inv;
  wire cond_lvl = act_ff.halve ? half_ff : muxed;
  wire if2_raw = run && cond_lvl;

  // a setup change parks the clock low, then resumes on a low level
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      csw_ff <= acd_pkg::CS_RUN;
      act_ff <= '0;
      half_ff <= 1'b0;
      mux_prev_ff <= 1'b0;
    end else begin
      mux_prev_ff <= muxed;
      unique case (csw_ff)
        acd_pkg::CS_RUN: begin
          if (req != act_ff && !cond_lvl) begin
            csw_ff <= acd_pkg::CS_PARK;
          end else if (muxed && !mux_prev_ff) begin
            half_ff <= !half_ff;
          end
        end
        acd_pkg::CS_PARK: begin
          if (!req_lvl) begin
            act_ff <= req;
            half_ff <= 1'b0;
            mux_prev_ff <= 1'b0;
            csw_ff <= acd_pkg::CS_RUN;
          end
        end
      endcase
    end
  end

  // ---------------- system clock select ----------------
  logic sys_act_ff;
  logic [acd_pkg::NGATE-1:0] gate_ff;
  logic [acd_pkg::NGATE-1:0] clk_ff;
  wire p2_lvl = clk_ff[0];
  wire sys_raw = sys_act_ff ? p2_lvl : p1_raw;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sys_act_ff <= 1'b0;
    end else if (!p1_raw && !p2_lvl) begin
      sys_act_ff <= gates_ff.sys_src;
    end
  end

  // ---------------- reference dividers ----------------
  logic ref_prev_ff;
  logic [acd_pkg::DIV_W-1:0] div_cnt_ff;
  wire ref_rise = ref_raw && !ref_prev_ff;
  wire [4:0] to_bit = acd_pkg::TO_BASE_BIT + 5'(aux_ff.to_div);
  wire [4:0] db_bit = (aux_ff.db_div == 3'h0) ? acd_pkg::DB_CODE0_BIT :
                      acd_pkg::DB_BASE_BIT + 5'(aux_ff.db_div);
  wire to_raw = div_cnt_ff[to_bit];
  wire db_raw = div_cnt_ff[db_bit];
  logic db_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ref_prev_ff <= 1'b0;
      div_cnt_ff <= '0;
      db_ff <= 1'b0;
    end else begin
      ref_prev_ff <= ref_raw;
      db_ff <= db_raw;
      if (ref_rise) begin
        div_cnt_ff <= div_cnt_ff + 1'b1;
      end
    end
  end

  // ---------------- gpio output clock ----------------
  logic sys_prev_ff;
  logic [4:0] op_cnt_ff;
  logic [4:0] op_n_ff;
  logic op_ff;
  wire sys_edge = sys_raw != sys_prev_ff;
  wire op_wrap = op_cnt_ff == op_n_ff - 5'h01;

  // divisor is taken at a toggle so a period is never cut short
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sys_prev_ff <= 1'b0;
      op_cnt_ff <= '0;
      op_n_ff <= acd_pkg::op_edges(3'h0);
      op_ff <= 1'b0;
    end else begin
      sys_prev_ff <= sys_raw;
      if (sys_edge) begin
        if (op_wrap) begin
          op_cnt_ff <= '0;
          op_ff <= !op_ff;
          op_n_ff <= acd_pkg::op_edges(aux_ff.op_div);
        end else begin
          op_cnt_ff <= op_cnt_ff + 5'h01;
        end
      end
    end
  end

  // ---------------- clock gates ----------------
  wire [acd_pkg::NGATE-1:0] gate_raw = {to_raw, sys_raw, p2_lvl, p1_raw, if2_raw};
  wire [acd_pkg::NGATE-1:0] gate_en = {gates_ff.to_ena, gates_ff.mix_ena,
    gates_ff.p2_ena, gates_ff.p1_ena, if2_ff.ena};

  // enables move only while the source is low
  genvar gi;
  generate
    for (gi = 0; gi < acd_pkg::NGATE; gi++) begin : g_gate
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          gate_ff[gi] <= 1'b0;
          clk_ff[gi] <= 1'b0;
        end else begin
          gate_ff[gi] <= gate_raw[gi] ? gate_ff[gi] : gate_en[gi];
          clk_ff[gi] <= gate_raw[gi] && gate_ff[gi];
        end
      end
    end
  endgenerate

  // ---------------- rate settings ----------------
  logic sys_ff;
  logic [10:0] ratio_ff;
  logic invalid_ff;
  wire sr_bad = rate_ff.sr > acd_pkg::SR_MAX;
  wire ratio_bad = rate_ff.ratio < acd_pkg::RATIO_MIN || rate_ff.ratio > acd_pkg::RATIO_MAX;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sys_ff <= 1'b0;
      ratio_ff <= '0;
      invalid_ff <= 1'b0;
    end else begin
      sys_ff <= sys_raw;
      ratio_ff <= acd_pkg::ratio_value(rate_ff.ratio);
      invalid_ff <= sr_bad || ratio_bad;
    end
  end

  assign status_w = {10'h000, invalid_ff, ratio_bad, sr_bad, clk_ff[0], run, sys_act_ff};

  assign second_port_clock = clk_ff[0];
  assign first_port_proc_clock = clk_ff[1];
  assign second_port_proc_clock = clk_ff[2];
  assign mixer_proc_clock = clk_ff[3];
  assign timeout_clock = clk_ff[4];
  assign system_clock = sys_ff;
  assign debounce_clock = db_ff;
  assign gpio_out_clock = op_ff;
  assign first_port_sample_rate = rate_ff.sr;
  assign first_port_clock_ratio = rate_ff.ratio;
  assign first_port_ratio_value = ratio_ff;
  assign first_port_rate_invalid = invalid_ff;

  // ---------------- checks ----------------
  a_src_route: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(act_ff.src) |-> act_ff.src == $past(req.src) && $past(csw_ff) == acd_pkg::CS_PARK)
    else $error("second port source changed outside park");
  a_inv_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    run && act_ff == req && !act_ff.halve && gate_ff[0] |=> second_port_clock == $past(req_lvl))
    else $error("invert not applied");
  a_halve_step: assert property (@(posedge ref_clk) disable iff (!resetn)
    run && act_ff.halve && muxed && !mux_prev_ff && !(req != act_ff && !cond_lvl)
    |=> half_ff != $past(half_ff))
    else $error("halved clock missed a toggle");
  a_if2_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    !if2_ff.ena && !gate_ff[0] |=> !second_port_clock)
    else $error("second port clock runs while disabled");
  a_to_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    !gates_ff.to_ena && !gate_ff[4] |=> !timeout_clock)
    else $error("timeout clock runs while disabled");
  a_p1_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    gate_ff[1] && p1_raw |=> first_port_proc_clock)
    else $error("first port processing clock not passed");
  a_p2_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    !gates_ff.p2_ena && !gate_ff[2] |=> !second_port_proc_clock)
    else $error("second port processing clock runs while disabled");
  a_mix_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    !gates_ff.mix_ena && !gate_ff[3] |=> !mixer_proc_clock)
    else $error("mixer clock runs while disabled");
  a_sys_swap: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(sys_act_ff) |-> !$past(p1_raw) && !$past(p2_lvl) && sys_act_ff == $past(gates_ff.sys_src))
    else $error("system clock switched on a high level");
  a_op_period: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(op_ff) |-> $past(op_cnt_ff) == $past(op_n_ff) - 5'h01 && $past(sys_edge))
    else $error("gpio clock toggled off count");
  a_rate_reset: assert property (@(posedge ref_clk)
    !resetn |=> rate_ff == acd_pkg::IF1_RATE_RST)
    else $error("rate register reset value wrong");
  a_gate_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(gate_ff) |-> ($past(gate_raw) & (gate_ff ^ $past(gate_ff))) == '0)
    else $error("gate moved while source high");
endmodule

// [sim/tb_audio_clock_select_divide.sv]
`timescale 1ns/10ps
module tb_audio_clock_select_divide;
  localparam int LIM = 30000;
  localparam logic [15:0] A_IF2 = {2'h0, acd_pkg::IDX_IF2_CLK, 2'h0};
  localparam logic [15:0] A_GAT = {2'h0, acd_pkg::IDX_GATES, 2'h0};
  localparam logic [15:0] A_AUX = {2'h0, acd_pkg::IDX_AUX_DIV, 2'h0};
  localparam logic [15:0] A_RAT = {2'h0, acd_pkg::IDX_IF1_RATE, 2'h0};
  localparam logic [15:0] A_STS = {2'h0, acd_pkg::IDX_STATUS, 2'h0};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // primary, secondary, first loop, second loop, first port, 256k reference
  logic [5:0] pins = 6'h00;
  int hp [6] = '{8, 12, 20, 28, 10, 2};
  int tc [6] = '{0, 0, 0, 0, 0, 0};
  int psrc [4] = '{16, 24, 40, 56};
  int opn [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
  int rtab [16] = '{0, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536, 0, 0, 0, 0, 0, 0};
  wire [7:0] co;
  logic [3:0] sr;
  logic [3:0] ratio;
  logic [10:0] rval;
  logic inval;
  logic [7:0] hist = 8'h00;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int n_compared = 0;
  int n;

  always #2 ref_clk = ~ref_clk;

  // source pins change on ref_clk edges so their periods are exact cycle counts
  always @(posedge ref_clk) begin
    for (int i = 0; i < 6; i++) begin
      if (tc[i] == hp[i] - 1) begin
        tc[i] <= 0;
        pins[i] <= ~pins[i];
      end else begin
        tc[i] <= tc[i] + 1;
      end
    end
    hist <= {hist[6:0], pins[0]};
  end

  acd_clock_ctrl dut (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_master_clock(pins[0]), .secondary_master_clock(pins[1]),
    .first_locked_loop(pins[2]), .second_locked_loop(pins[3]),
    .first_port_clock(pins[4]), .ref_256k_clock(pins[5]),
    .second_port_clock(co[0]), .system_clock(co[1]), .first_port_proc_clock(co[2]),
    .second_port_proc_clock(co[3]), .mixer_proc_clock(co[4]), .timeout_clock(co[5]),
    .debounce_clock(co[6]), .gpio_out_clock(co[7]),
    .first_port_sample_rate(sr), .first_port_clock_ratio(ratio),
    .first_port_ratio_value(rval), .first_port_rate_invalid(inval)
  );

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    n_mismatch++;
    $display("CHECK FAILED at %0t got %h exp %h", $time, 32'h0, 32'h1);
    end_sim();
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) timed_out();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cmp_reg({31'h0, er}, 32'h0);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0);
    cmp_reg(rd, exp);
    cmp_reg({31'h0, er}, {31'h0, experr});
  endtask

  task automatic wait_rise(input int k, output int c);
    logic p;
    p = co[k];
    c = 0;
    while (c < LIM) begin
      @(posedge ref_clk);
      c++;
      if (co[k] === 1'b1 && p !== 1'b1) break;
      p = co[k];
    end
    if (c >= LIM) timed_out();
  endtask

  // two rises let a new setting settle, the third gives the period
  task automatic period(input int k, input int exp);
    int c;
    wait_rise(k, c);
    wait_rise(k, c);
    wait_rise(k, c);
    cmp_cnt(c, exp);
  endtask

  task automatic rises(input int k, input int win, output int c);
    logic p;
    // let an edge already in flight through a closing gate pass first
    repeat (2) @(posedge ref_clk);
    p = co[k];
    c = 0;
    repeat (win) begin
      @(posedge ref_clk);
      if (co[k] === 1'b1 && p !== 1'b1) c++;
      p = co[k];
    end
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmp_reg({28'h0, sr}, 32'h8);
    cmp_reg({17'h0, ratio, rval}, {17'h0, 4'h3, 11'h100});
    for (int k = 0; k < 6; k++) begin
      if (k != 1) begin
        rises(k, 300, n);
        cmp_cnt(n, 0);
      end
    end
    period(1, 20);
    rd_chk(A_IF2, 32'h0, 1'b0);
    rd_chk(A_GAT, 32'h0, 1'b0);
    rd_chk(A_AUX, 32'h0, 1'b0);
    rd_chk(A_RAT, 32'h83, 1'b0);
    rd_chk(16'h0000, 32'h0, 1'b1);
    apb(1'b1, A_STS, 32'hffff);
    cmp_reg({31'h0, er}, 32'h1);
    wr_reg(A_IF2, 32'hffffffff);
    rd_chk(A_IF2, 32'h1f, 1'b0);
    wr_reg(A_GAT, 32'hffffffff);
    rd_chk(A_GAT, 32'h1f, 1'b0);
    wr_reg(A_AUX, 32'hffffffff);
    rd_chk(A_AUX, 32'h777, 1'b0);
    wr_reg(A_GAT, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr_reg(A_IF2, (s << 3) | 1);
      period(0, psrc[s]);
    end
    wr_reg(A_IF2, 32'h0b);
    period(0, 48);
    for (int v = 0; v < 2; v++) begin
      wr_reg(A_IF2, (v << 2) | 1);
      period(0, 16);
      n = 0;
      repeat (32) begin
        @(posedge ref_clk);
        if (co[0] === (hist[2] ^ v[0])) n++;
      end
      cmp_cnt(n, 32);
    end
    wr_reg(A_IF2, 32'h01);
    wr_reg(A_GAT, 32'h0e);
    period(2, 20);
    period(3, 16);
    period(4, 20);
    wr_reg(A_GAT, 32'h0f);
    period(1, 16);
    period(4, 16);
    wr_reg(A_GAT, 32'h00);
    for (int k = 2; k < 5; k++) begin
      rises(k, 100, n);
      cmp_cnt(n, 0);
    end
    for (int c = 0; c < 8; c++) begin
      wr_reg(A_AUX, c);
      period(7, 20 * opn[c]);
    end
    wr_reg(A_GAT, 32'h10);
    for (int c = 0; c < 2; c++) begin
      wr_reg(A_AUX, (c << 8) | (c << 4));
      period(5, 1024 << c);
      period(6, 1024 << (3 * c));
    end
    wr_reg(A_GAT, 32'h00);
    rises(5, 2200, n);
    cmp_cnt(n, 0);
    for (int c = 0; c < 16; c++) begin
      wr_reg(A_RAT, 32'h80 | c);
      repeat (3) @(posedge ref_clk);
      cmp_reg({17'h0, ratio, rval}, {17'h0, c[3:0], 11'(rtab[c])});
      cmp_reg({31'h0, inval}, {31'h0, c == 0 || c > 9});
      wr_reg(A_RAT, (c << 4) | 3);
      repeat (3) @(posedge ref_clk);
      cmp_reg({28'h0, sr}, c);
      cmp_reg({31'h0, inval}, {31'h0, c > 10});
    end
    end_sim();
  end
endmodule
